// file: logic/ppfs_cfg.svh
// Constants of the paper pickup and feed sequencer: timing, offsets, fields.
`ifndef PPFS_CFG_SVH
`define PPFS_CFG_SVH

// Engine clock and the printed times in nanoseconds.
`define PPFS_CLK_MHZ          125
`define PPFS_MOTOR_SETTLE_NS  10000
`define PPFS_SOL_ON_NS        20000
`define PPFS_SELFTEST_NS      100000

// Register byte offsets.
`define PPFS_OFS_CTRL         8'h00
`define PPFS_OFS_STATUS       8'h04
`define PPFS_OFS_IRQ_STAT     8'h08
`define PPFS_OFS_IRQ_MASK     8'h0C
`define PPFS_OFS_MEDIA_CFG    8'h10

// Control register fields.
`define PPFS_CTRL_START       0
`define PPFS_CTRL_BYPASS      1
`define PPFS_CTRL_DUPLEX      2
`define PPFS_CTRL_ACK         3
`define PPFS_CTRL_MODE_LSB    4
`define PPFS_CTRL_MODE_MSB    7

// Event bits of the interrupt status; bits 0 to 3 also index the pending notices.
`define PPFS_EV_NOPAPER       0
`define PPFS_EV_LAST          1
`define PPFS_EV_MISMATCH      2
`define PPFS_EV_SENSFAIL      3
`define PPFS_EV_DONE          4

// Reset values.
`define PPFS_MASK_RST         5'h00
`define PPFS_EXPECT_RST       8'h80
`define PPFS_TOL_RST          8'h10

// Media sensor thresholds on the 8-bit readings.
`define PPFS_TRANS_CLEAR      8'hE0
`define PPFS_GLOSS_FILM       8'hE0
`define PPFS_GLOSS_HI         8'hA0
`define PPFS_TRANS_HEAVY1     8'h90
`define PPFS_TRANS_HEAVY2     8'h60
`define PPFS_TRANS_HEAVY3     8'h30

// AXI responses.
`define PPFS_RESP_OKAY        2'h0
`define PPFS_RESP_SLVERR      2'h2

`endif

// file: logic/ppfs_pkg.sv
// Types of the paper pickup and feed sequencer.
package ppfs_pkg;

  typedef enum logic [3:0] {
    PPFS_AUTO, PPFS_NORMAL, PPFS_LIGHT1, PPFS_HEAVY1, PPFS_HEAVY2,
    PPFS_HEAVY3, PPFS_GLOSSY1, PPFS_GLOSSY2, PPFS_GLOSSY3,
    PPFS_GLOSSY_FILM, PPFS_ENVELOPE, PPFS_TRANSPARENCY, PPFS_LABEL
  } ppfs_media_e;

  typedef enum logic [2:0] {
    PPFS_SP_FULL, PPFS_SP_THREE_Q, PPFS_SP_HALF, PPFS_SP_THIRD, PPFS_SP_TENTH
  } ppfs_speed_e;

  typedef enum logic [2:0] {
    PPFS_N_NONE, PPFS_N_NOPAPER, PPFS_N_LAST, PPFS_N_MISMATCH, PPFS_N_SENSFAIL
  } ppfs_notif_e;

  typedef enum logic [2:0] {
    ST_SELFTEST, ST_IDLE, ST_WAIT_PAPER, ST_MOTOR, ST_PICK, ST_FEED,
    ST_HOLD, ST_REFEED
  } ppfs_state_e;

  typedef struct packed {
    logic       present;
    logic       last;
    logic       vsync;
    logic       aligned;
    logic       wake;
    logic [7:0] gloss;
    logic [7:0] trans;
    logic [7:0] intensity;
  } ppfs_sensors_s;

  typedef struct packed {
    logic        pickup_on;
    logic        pickup_rev;
    logic        bypass_sol;
    logic        cassette_sol;
    logic        reg_motor_on;
    logic        emitter_on;
    ppfs_speed_e speed;
  } ppfs_drive_s;

  typedef struct packed {
    ppfs_media_e ptype;
    ppfs_speed_e speed;
    logic        mismatch;
  } ppfs_media_s;

endpackage : ppfs_pkg

// file: logic/ppfs_media.sv
// Media classifier, feed-speed selection and job-mode mismatch check.
`include "ppfs_cfg.svh"

module ppfs_media
  import ppfs_pkg::*;
(
  input  wire logic [7:0]  gloss,
  input  wire logic [7:0]  trans,
  input  wire logic [3:0]  mode,
  input  wire logic        duplex,
  output var  ppfs_media_s result
);

  ppfs_media_e sensed;
  ppfs_media_e job;
  ppfs_media_e pick;
  logic        dup_ok;

  // Gloss and transmission readings give the type, the job mode may
  // override it for stock that the sensor cannot see.
  always_comb begin
    sensed = PPFS_NORMAL;
    job    = ppfs_media_e'(mode);
    if (trans >= `PPFS_TRANS_CLEAR) begin
      sensed = PPFS_TRANSPARENCY;
    end else if (gloss >= `PPFS_GLOSS_FILM) begin
      sensed = PPFS_GLOSSY_FILM;
    end else if (trans < `PPFS_TRANS_HEAVY3) begin
      sensed = (gloss >= `PPFS_GLOSS_HI) ? PPFS_GLOSSY3 : PPFS_HEAVY3;
    end else if (trans < `PPFS_TRANS_HEAVY2) begin
      sensed = (gloss >= `PPFS_GLOSS_HI) ? PPFS_GLOSSY2 : PPFS_HEAVY2;
    end else if (trans < `PPFS_TRANS_HEAVY1) begin
      sensed = (gloss >= `PPFS_GLOSS_HI) ? PPFS_GLOSSY1 : PPFS_HEAVY1;
    end else begin
      sensed = (gloss >= `PPFS_GLOSS_HI) ? PPFS_GLOSSY1 : PPFS_NORMAL;
    end
    // Light, envelope and label look like plain stock to the sensor.
    pick = sensed;
    if (job == PPFS_LIGHT1 || job == PPFS_ENVELOPE || job == PPFS_LABEL) begin
      pick = job;
    end
    result.ptype = pick;
    case (pick)
      PPFS_HEAVY1, PPFS_GLOSSY1: result.speed = PPFS_SP_THREE_Q;
      PPFS_HEAVY2, PPFS_GLOSSY2,
      PPFS_LABEL:                result.speed = PPFS_SP_HALF;
      PPFS_HEAVY3, PPFS_GLOSSY3: result.speed = PPFS_SP_THIRD;
      PPFS_GLOSSY_FILM,
      PPFS_TRANSPARENCY:         result.speed = PPFS_SP_TENTH;
      default:                   result.speed = PPFS_SP_FULL;
    endcase
    // Modes that cannot go through the duplex path are not duplex capable.
    dup_ok = !(job == PPFS_AUTO || job == PPFS_TRANSPARENCY ||
               job == PPFS_GLOSSY_FILM || job == PPFS_ENVELOPE ||
               job == PPFS_LABEL);
    if (duplex) begin
      result.mismatch = dup_ok && sensed == PPFS_TRANSPARENCY;
    end else if (job == PPFS_TRANSPARENCY) begin
      result.mismatch = sensed != PPFS_TRANSPARENCY;
    end else begin
      result.mismatch = job != PPFS_AUTO &&
                        sensed == PPFS_TRANSPARENCY;
    end
  end

endmodule : ppfs_media

// file: logic/ppfs_seq.sv
// Pickup and feed sequencer with its AXI4-Lite register file.
`include "ppfs_cfg.svh"

// How it works
// - An empty bypass tray raises a no-paper notice.
// - Bypass printing waits until the tray reports paper.
// - A bypass print first runs the pickup motor in reverse.
// - With the motor reversed, the bypass pickup solenoid is energised.
// - A turning last-sheet roller raises a last-sheet notice.
// - That notice comes at once, not when the tray later looks empty.
// - Leading edge at the sync sensor stops the registration motor.
// - While the sheet is held, the media sensors are sampled.
// - Belt alignment restarts the registration motor.
// - Gloss and transmission readings are combined into a paper type.
// - Simplex transparency job on other media is a mismatch.
// - Simplex non-auto, non-transparency job on transparency mismatches.
// - Duplex-capable job sensing a transparency is a mismatch.
// - Power-up and wake test the emitter against the expected intensity.
// - Undetectable stock takes its feed speed from the job mode.
// - Feed speed follows the per-mode speed table.
// - Cassette pickup runs the motor forward, then its solenoid.
module ppfs_seq
  import ppfs_pkg::*;
#(
  parameter int SELFTEST_CYC =
    (`PPFS_SELFTEST_NS * `PPFS_CLK_MHZ + 999) / 1000
)
(
  input  wire logic          SYS_CLK,
  input  wire logic          RESETN,
  input  wire ppfs_sensors_s SENSORS,
  output var  ppfs_drive_s   DRIVE,
  output var  logic          IRQ,
  input  wire logic          S_AXI_AWVALID,
  output var  logic          S_AXI_AWREADY,
  input  wire logic [7:0]    S_AXI_AWADDR,
  input  wire logic          S_AXI_WVALID,
  output var  logic          S_AXI_WREADY,
  input  wire logic [31:0]   S_AXI_WDATA,
  input  wire logic [3:0]    S_AXI_WSTRB,
  output var  logic          S_AXI_BVALID,
  input  wire logic          S_AXI_BREADY,
  output var  logic [1:0]    S_AXI_BRESP,
  input  wire logic          S_AXI_ARVALID,
  output var  logic          S_AXI_ARREADY,
  input  wire logic [7:0]    S_AXI_ARADDR,
  output var  logic          S_AXI_RVALID,
  input  wire logic          S_AXI_RREADY,
  output var  logic [31:0]   S_AXI_RDATA,
  output var  logic [1:0]    S_AXI_RRESP
);

  localparam int SETTLE_CYC =
    (`PPFS_MOTOR_SETTLE_NS * `PPFS_CLK_MHZ + 999) / 1000;
  localparam int SOL_CYC = (`PPFS_SOL_ON_NS * `PPFS_CLK_MHZ + 999) / 1000;
  localparam logic [15:0] SETTLE_LOAD = 16'(SETTLE_CYC - 1);
  localparam logic [15:0] SOL_LOAD    = 16'(SOL_CYC - 1);
  localparam logic [15:0] SELF_LOAD   = 16'(SELFTEST_CYC - 1);

  typedef struct packed {
    ppfs_sensors_s sy1;
    ppfs_sensors_s sy2;
    ppfs_sensors_s prev;
    ppfs_state_e   state;
    logic [15:0]   cnt;
    logic          job_bypass;
    ppfs_drive_s   drv;
    ppfs_media_s   media;
    logic          sens_fail;
    logic [3:0]    pend;
    logic [3:0]    disp;
    ppfs_notif_e   code;
    logic [31:0]   ctrl;
    logic [4:0]    irq_stat;
    logic [4:0]    mask;
    logic [7:0]    expect_lvl;
    logic [7:0]    tol;
    logic          irq;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
    logic          aw_have;
    logic          w_have;
    logic [7:0]    aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
  } ppfs_regs_s;

  ppfs_regs_s  s;
  ppfs_regs_s  n;
  ppfs_media_s med;
  logic [31:0] strb_mask;
  logic [31:0] old_word;
  logic [31:0] merged;
  logic [31:0] status_word;
  logic [7:0]  diff;
  logic [4:0]  ev;
  logic        start_req;
  logic        ack_req;
  logic        clr_irq;
  logic        rise_last;
  logic        rise_wake;
  logic        fall_present;

  // Each written byte lane replaces only its own eight bits.
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign strb_mask[8*i +: 8] = {8{s.w_strb[i]}};
  end

  // The classifier sees synchronised readings and the stored job mode.
  ppfs_media u_media (
    .gloss  (s.sy2.gloss),
    .trans  (s.sy2.trans),
    .mode   (s.ctrl[`PPFS_CTRL_MODE_MSB:`PPFS_CTRL_MODE_LSB]),
    .duplex (s.ctrl[`PPFS_CTRL_DUPLEX]),
    .result (med)
  );

  // Edge detectors look only at the second synchroniser stage.
  assign rise_last    = s.sy2.last && !s.prev.last;
  assign rise_wake    = s.sy2.wake && !s.prev.wake;
  assign fall_present = !s.sy2.present && s.prev.present;
  assign diff = (s.sy2.intensity >= s.expect_lvl) ?
                s.sy2.intensity - s.expect_lvl :
                s.expect_lvl - s.sy2.intensity;
  assign status_word = {17'h0, s.sy2.present, s.sens_fail, s.code,
                        s.media.speed, s.media.ptype, s.state};

  // Next-state logic for the bus slave, the sequencer and the notices.
  always_comb begin
    n         = s;
    ev        = '0;
    start_req = 1'b0;
    ack_req   = 1'b0;
    clr_irq   = 1'b0;
    old_word  = '0;
    n.sy1     = SENSORS;
    n.sy2     = s.sy1;
    n.prev    = s.sy2;
    // Address and data may come in either order; each is parked alone.
    if (S_AXI_AWVALID && s.awready) begin
      n.aw_have = 1'b1;
      n.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && s.wready) begin
      n.w_have = 1'b1;
      n.w_data = S_AXI_WDATA;
      n.w_strb = S_AXI_WSTRB;
    end
    if (S_AXI_BREADY && s.bvalid) begin
      n.bvalid = 1'b0;
    end
    case (s.aw_addr)
      `PPFS_OFS_CTRL:      old_word = s.ctrl;
      `PPFS_OFS_IRQ_MASK:  old_word = {27'h0, s.mask};
      `PPFS_OFS_MEDIA_CFG: old_word = {16'h0, s.tol, s.expect_lvl};
      default:             old_word = '0;
    endcase
    merged = (old_word & ~strb_mask) | (s.w_data & strb_mask);
    if (s.aw_have && s.w_have && !s.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = `PPFS_RESP_OKAY;
      case (s.aw_addr)
        `PPFS_OFS_CTRL: begin
          // Start and acknowledge are actions and always read back as zero.
          start_req = merged[`PPFS_CTRL_START];
          ack_req   = merged[`PPFS_CTRL_ACK];
          n.ctrl    = merged;
          n.ctrl[`PPFS_CTRL_START] = 1'b0;
          n.ctrl[`PPFS_CTRL_ACK]   = 1'b0;
        end
        `PPFS_OFS_IRQ_MASK: n.mask = merged[4:0];
        `PPFS_OFS_MEDIA_CFG: begin
          n.expect_lvl = merged[7:0];
          n.tol        = merged[15:8];
        end
        `PPFS_OFS_STATUS, `PPFS_OFS_IRQ_STAT: n.bresp = `PPFS_RESP_OKAY;
        default: n.bresp = `PPFS_RESP_SLVERR;
      endcase
    end
    // Reads answer one cycle after the address is taken.
    if (S_AXI_RREADY && s.rvalid) begin
      n.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = `PPFS_RESP_OKAY;
      case (S_AXI_ARADDR)
        `PPFS_OFS_CTRL:      n.rdata = s.ctrl;
        `PPFS_OFS_STATUS:    n.rdata = status_word;
        `PPFS_OFS_IRQ_STAT: begin
          n.rdata = {27'h0, s.irq_stat};
          clr_irq = 1'b1;
        end
        `PPFS_OFS_IRQ_MASK:  n.rdata = {27'h0, s.mask};
        `PPFS_OFS_MEDIA_CFG: n.rdata = {16'h0, s.tol, s.expect_lvl};
        default: begin
          n.rdata = '0;
          n.rresp = `PPFS_RESP_SLVERR;
        end
      endcase
    end
    n.awready = !n.aw_have && !n.bvalid;
    n.wready  = !n.w_have && !n.bvalid;
    n.arready = !n.rvalid;

    // Sheet sequence.
    case (s.state)
      ST_SELFTEST: begin
        if (s.cnt == '0) begin
          n.drv.emitter_on = 1'b0;
          n.state          = ST_IDLE;
          n.sens_fail      = diff > s.tol;
          ev[`PPFS_EV_SENSFAIL] = diff > s.tol;
        end else begin
          n.cnt = s.cnt - 16'h0001;
        end
      end
      ST_IDLE: begin
        ev[`PPFS_EV_NOPAPER] = fall_present;
        if (rise_wake) begin
          n.state          = ST_SELFTEST;
          n.drv.emitter_on = 1'b1;
          n.cnt            = SELF_LOAD;
        end else if (start_req) begin
          n.job_bypass = merged[`PPFS_CTRL_BYPASS];
          if (merged[`PPFS_CTRL_BYPASS] && !s.sy2.present) begin
            n.state = ST_WAIT_PAPER;
            ev[`PPFS_EV_NOPAPER] = 1'b1;
          end else begin
            n.state          = ST_MOTOR;
            n.drv.pickup_on  = 1'b1;
            n.drv.pickup_rev = n.job_bypass;
            n.cnt            = SETTLE_LOAD;
          end
        end
      end
      ST_WAIT_PAPER: begin
        if (s.sy2.present) begin
          n.state          = ST_MOTOR;
          n.drv.pickup_on  = 1'b1;
          n.drv.pickup_rev = 1'b1;
          n.cnt            = SETTLE_LOAD;
        end
      end
      ST_MOTOR: begin
        // The solenoid waits for the motor to settle in its direction.
        if (s.cnt == '0) begin
          n.state            = ST_PICK;
          n.drv.bypass_sol   = s.job_bypass;
          n.drv.cassette_sol = !s.job_bypass;
          n.drv.reg_motor_on = 1'b1;
          n.cnt              = SOL_LOAD;
        end else begin
          n.cnt = s.cnt - 16'h0001;
        end
      end
      ST_PICK: begin
        if (s.cnt == '0) begin
          n.state            = ST_FEED;
          n.drv.bypass_sol   = 1'b0;
          n.drv.cassette_sol = 1'b0;
          n.drv.pickup_on    = 1'b0;
          n.drv.pickup_rev   = 1'b0;
        end else begin
          n.cnt = s.cnt - 16'h0001;
        end
      end
      ST_FEED: begin
        // A level test, so an edge that came during the pick is not lost.
        if (s.sy2.vsync) begin
          n.state            = ST_HOLD;
          n.drv.reg_motor_on = 1'b0;
        end
      end
      ST_HOLD: begin
        n.media = med;
        if (s.sy2.aligned) begin
          n.state            = ST_REFEED;
          n.drv.reg_motor_on = 1'b1;
          n.drv.speed        = med.speed;
          ev[`PPFS_EV_MISMATCH] = med.mismatch;
        end
      end
      ST_REFEED: begin
        if (!s.sy2.vsync) begin
          n.state            = ST_IDLE;
          n.drv.reg_motor_on = 1'b0;
          ev[`PPFS_EV_DONE]  = 1'b1;
        end
      end
      default: begin
        n.state = ST_IDLE;
        n.drv   = '0;
      end
    endcase
    // The roller turns only for the last sheet, well before the tray empties.
    if (rise_last && s.job_bypass &&
        (s.state == ST_MOTOR || s.state == ST_PICK ||
         s.state == ST_FEED || s.state == ST_HOLD)) begin
      ev[`PPFS_EV_LAST] = 1'b1;
    end

    // The shown code stays until acknowledged; a new event wins the clear.
    n.pend = (ack_req ? (s.pend & ~s.disp) : s.pend) | ev[3:0];
    n.disp = s.disp & n.pend;
    if (n.disp == '0) begin
      if (n.pend[`PPFS_EV_SENSFAIL]) begin
        n.disp = 4'h8;
      end else if (n.pend[`PPFS_EV_NOPAPER]) begin
        n.disp = 4'h1;
      end else if (n.pend[`PPFS_EV_LAST]) begin
        n.disp = 4'h2;
      end else if (n.pend[`PPFS_EV_MISMATCH]) begin
        n.disp = 4'h4;
      end
    end
    case (n.disp)
      4'h1:    n.code = PPFS_N_NOPAPER;
      4'h2:    n.code = PPFS_N_LAST;
      4'h4:    n.code = PPFS_N_MISMATCH;
      4'h8:    n.code = PPFS_N_SENSFAIL;
      default: n.code = PPFS_N_NONE;
    endcase
    n.irq_stat = (clr_irq ? 5'h00 : s.irq_stat) | ev;
    n.irq      = |(n.irq_stat & n.mask);
  end

  // One register for all state; the emitter starts on for the power-up test.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s                <= '0;
      s.state          <= ST_SELFTEST;
      s.cnt            <= SELF_LOAD;
      s.drv.emitter_on <= 1'b1;
      s.mask           <= `PPFS_MASK_RST;
      s.expect_lvl     <= `PPFS_EXPECT_RST;
      s.tol            <= `PPFS_TOL_RST;
    end else begin
      s <= n;
    end
  end

  assign DRIVE         = s.drv;
  assign IRQ           = s.irq;
  assign S_AXI_AWREADY = s.awready;
  assign S_AXI_WREADY  = s.wready;
  assign S_AXI_BVALID  = s.bvalid;
  assign S_AXI_BRESP   = s.bresp;
  assign S_AXI_ARREADY = s.arready;
  assign S_AXI_RVALID  = s.rvalid;
  assign S_AXI_RDATA   = s.rdata;
  assign S_AXI_RRESP   = s.rresp;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);

  nopaper_notice_a: assert property (
    s.state == ST_IDLE && !rise_wake && start_req &&
    merged[`PPFS_CTRL_BYPASS] && !s.sy2.present
    |=> s.pend[`PPFS_EV_NOPAPER] && s.irq_stat[`PPFS_EV_NOPAPER])
    else $error("No-paper notice missing.");
  hold_off_a: assert property (
    s.state == ST_WAIT_PAPER |-> !s.drv.pickup_on && !s.drv.bypass_sol)
    else $error("Bypass pickup ran without paper.");
  reverse_first_a: assert property (
    $rose(s.drv.pickup_on) && s.job_bypass
    |-> s.drv.pickup_rev && !s.drv.bypass_sol)
    else $error("Bypass pickup motor not reversed first.");
  sol_after_rev_a: assert property (
    $rose(s.drv.bypass_sol) |-> $past(s.drv.pickup_on, 2) &&
    s.drv.pickup_rev && $past(s.state) == ST_MOTOR)
    else $error("Bypass solenoid before reversed motor.");
  last_notice_a: assert property (
    rise_last && s.job_bypass && s.state == ST_FEED
    |=> s.pend[`PPFS_EV_LAST] && s.irq_stat[`PPFS_EV_LAST])
    else $error("Last-sheet notice late or missing.");
  reg_stop_a: assert property (
    s.state == ST_FEED && s.sy2.vsync
    |=> s.state == ST_HOLD && !s.drv.reg_motor_on)
    else $error("Registration motor not stopped at sync.");
  media_sample_a: assert property (
    s.state == ST_HOLD |=> s.media == $past(med))
    else $error("Media not sampled while held.");
  reg_restart_a: assert property (
    s.state == ST_HOLD && s.sy2.aligned
    |=> s.state == ST_REFEED && s.drv.reg_motor_on &&
        s.drv.speed == $past(med.speed))
    else $error("Registration restart or speed wrong.");
  mismatch_a: assert property (
    s.state == ST_HOLD && s.sy2.aligned && med.mismatch
    |=> s.pend[`PPFS_EV_MISMATCH])
    else $error("Type mismatch not flagged.");
  selftest_a: assert property (
    s.state == ST_IDLE && rise_wake
    |=> s.drv.emitter_on && s.state == ST_SELFTEST)
    else $error("Wake did not start emitter test.");
  notice_held_a: assert property (
    s.code != PPFS_N_NONE && !ack_req |=> s.code == $past(s.code))
    else $error("Notice code changed without acknowledge.");
  cassette_fwd_a: assert property (
    $rose(s.drv.cassette_sol) |-> s.drv.pickup_on && !s.drv.pickup_rev)
    else $error("Cassette solenoid without forward motor.");

endmodule : ppfs_seq

// file: dv/ppfs_fmt.sv
// Formatter model: an AXI4-Lite master that issues commands and polls.
module ppfs_fmt (
  input  wire logic        SYS_CLK,
  input  wire logic        S_AXI_AWREADY,
  input  wire logic        S_AXI_WREADY,
  input  wire logic        S_AXI_BVALID,
  input  wire logic [1:0]  S_AXI_BRESP,
  input  wire logic        S_AXI_ARREADY,
  input  wire logic        S_AXI_RVALID,
  input  wire logic [31:0] S_AXI_RDATA,
  input  wire logic [1:0]  S_AXI_RRESP,
  output var  logic        S_AXI_AWVALID = 1'b0,
  output var  logic [7:0]  S_AXI_AWADDR = 8'h00,
  output var  logic        S_AXI_WVALID = 1'b0,
  output var  logic [31:0] S_AXI_WDATA = 32'h0,
  output var  logic [3:0]  S_AXI_WSTRB = 4'hF,
  output var  logic        S_AXI_BREADY = 1'b1,
  output var  logic        S_AXI_ARVALID = 1'b0,
  output var  logic [7:0]  S_AXI_ARADDR = 8'h00,
  output var  logic        S_AXI_RREADY = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;

  // Address and data go out together; each drops only when it is taken.
  // The ready for answers stays high, so no answer is ever left waiting.
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] resp);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    resp = S_AXI_BRESP;
  endtask : wr

  // One read; data and response are taken at the edge that shows valid.
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] resp);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    v = S_AXI_RDATA;
    resp = S_AXI_RRESP;
  endtask : rd
endmodule : ppfs_fmt

// file: dv/ppfs_seq_tb.sv
// Bench of the pickup and feed sequencer: random media and corner jobs.
`include "ppfs_cfg.svh"
module ppfs_seq_tb
  import ppfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK = 1'b0;
  logic RESETN = 1'b0;
  ppfs_sensors_s SENSORS = 29'h000A080;
  ppfs_drive_s DRIVE;
  logic IRQ, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, S_AXI_RREADY;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  ppfs_media_e tbl[10] = '{PPFS_HEAVY3, PPFS_HEAVY2, PPFS_HEAVY1,
    PPFS_NORMAL, PPFS_GLOSSY3, PPFS_GLOSSY2, PPFS_GLOSSY1, PPFS_GLOSSY1,
    PPFS_GLOSSY_FILM, PPFS_TRANSPARENCY};

  // A short self-test keeps power-up and wake checks quick.
  ppfs_seq #(.SELFTEST_CYC(20)) DUT (.*);
  ppfs_fmt fmt (.*);

  // Clock at 125 MHz.
  initial begin
    forever #4 SYS_CLK = ~SYS_CLK;
  end

  // Fifteen jobs of about four thousand cycles fit well below the limit.
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic chk(input string n, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic tk(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask : tk

  task automatic sta();
    fmt.rd(`PPFS_OFS_STATUS, d, r);
  endtask : sta

  task automatic ctl(input logic [7:0] c);
    fmt.wr(`PPFS_OFS_CTRL, {24'h0, c}, r);
    chk("bresp", r, 2'h0);
  endtask : ctl

  task automatic ack(input logic [7:0] c);
    ctl(c | 8'h08);
    sta();
    chk("notice ack", d[12:10], 3'h0);
  endtask : ack

  // Feed speed that a paper type or a job mode calls for.
  function automatic ppfs_speed_e spd(ppfs_media_e m);
    case (m)
      PPFS_HEAVY1, PPFS_GLOSSY1: return PPFS_SP_THREE_Q;
      PPFS_HEAVY2, PPFS_GLOSSY2, PPFS_LABEL: return PPFS_SP_HALF;
      PPFS_HEAVY3, PPFS_GLOSSY3: return PPFS_SP_THIRD;
      PPFS_GLOSSY_FILM, PPFS_TRANSPARENCY: return PPFS_SP_TENTH;
      default: return PPFS_SP_FULL;
    endcase
  endfunction : spd

  // Whether a job mode disagrees with the sensed stock.
  function automatic logic mm(logic [3:0] m, logic dx, ppfs_media_e s);
    logic t;
    t = (s == PPFS_TRANSPARENCY);
    if (dx)
      return t && !(m inside {4'h0, 4'h9, 4'hA, 4'hB, 4'hC});
    return (m == 4'hB) ? !t : (m != 4'h0) && t;
  endfunction : mm

  // One whole print job; an empty tray is filled only after the notice.
  task automatic job(input logic [3:0] m, input logic dx, bp,
                     input logic [7:0] g, t, input ppfs_media_e s);
    ppfs_media_e e;
    logic [7:0] c;
    e = (m inside {4'h2, 4'hA, 4'hC}) ? ppfs_media_e'(m) : s;
    c = {m, 1'b0, dx, bp, 1'b0};
    SENSORS.gloss <= g;
    SENSORS.trans <= t;
    ctl(c | 8'h01);
    if (!SENSORS.present) begin
      tk(8);
      sta();
      chk("wait paper", {d[2:0], DRIVE.pickup_on}, 4'h4);
      chk("no paper", d[12:10], 3'h1);
      chk("irq masked", IRQ, 1'b0);
      SENSORS.present <= 1'b1;
      ack(c);
    end
    do @(posedge SYS_CLK); while (!DRIVE.pickup_on);
    chk("pickup dir", DRIVE.pickup_rev, bp);
    do @(posedge SYS_CLK); while (!(DRIVE.bypass_sol | DRIVE.cassette_sol));
    chk("solenoid", {DRIVE.bypass_sol, DRIVE.cassette_sol, DRIVE.pickup_on,
        DRIVE.pickup_rev}, {bp, !bp, 1'b1, bp});
    do @(posedge SYS_CLK); while (DRIVE.pickup_on);
    if (bp) begin
      SENSORS.last <= 1'b1;
      tk(6);
      SENSORS.last <= 1'b0;
      sta();
      chk("last sheet", d[12:10], 3'h2);
      ack(c);
    end
    SENSORS.vsync <= 1'b1;
    do @(posedge SYS_CLK); while (DRIVE.reg_motor_on);
    tk(20);
    chk("held", DRIVE.reg_motor_on, 1'b0);
    SENSORS.aligned <= 1'b1;
    do @(posedge SYS_CLK); while (!DRIVE.reg_motor_on);
    tk(1);
    chk("drive speed", DRIVE.speed, spd(e));
    sta();
    chk("type", d[6:3], e);
    chk("speed", d[9:7], spd(e));
    chk("mismatch", d[12:10],
        mm(m, dx, s) ? 3'h3 : 3'h0);
    SENSORS.aligned <= 1'b0;
    SENSORS.vsync <= 1'b0;
    if (mm(m, dx, s)) ack(c);
    do sta(); while (d[2:0] != 3'h1);
    chk("irq done", IRQ, 1'b1);
    fmt.rd(`PPFS_OFS_IRQ_STAT, d, r);
    chk("done bit", d[4], 1'b1);
    tk(3);
    chk("irq cleared", IRQ, 1'b0);
  endtask : job

  // Main sequence: power-up test, bus corners, wake failure, then jobs.
  initial begin
    logic [7:0] g, t;
    void'($urandom(32'hC875));
    tk(10);
    RESETN <= 1'b1;
    tk(2);
    chk("emitter", DRIVE.emitter_on, 1'b1);
    do sta(); while (d[2:0] != 3'h1);
    chk("self test", d[13], 1'b0);
    fmt.rd(`PPFS_OFS_MEDIA_CFG, d, r);
    chk("media cfg", d, 32'h1080);
    fmt.rd(8'h20, d, r);
    chk("unmapped rd", d, 32'h0);
    chk("unmapped rresp", r, 2'h2);
    fmt.wr(8'h20, 32'h0, r);
    chk("unmapped wr", r, 2'h2);
    fmt.wr(`PPFS_OFS_IRQ_MASK, 32'h10, r);
    fmt.rd(`PPFS_OFS_IRQ_MASK, d, r);
    chk("irq mask", d, 32'h10);
    fmt.wr(`PPFS_OFS_STATUS, 32'h0, r);
    chk("ro write", r, 2'h0);
    SENSORS.intensity <= 8'h20;
    SENSORS.wake <= 1'b1;
    tk(6);
    chk("wake emitter", DRIVE.emitter_on, 1'b1);
    tk(40);
    SENSORS.wake <= 1'b0;
    SENSORS.intensity <= 8'h80;
    sta();
    chk("sensor fail", {d[13], d[12:10]}, 4'hC);
    ack(8'h00);
    job(4'h2, 1'b0, 1'b1, 8'h00, 8'hF0, PPFS_TRANSPARENCY);
    job(4'hA, 1'b1, 1'b1, 8'h00, 8'hA0, PPFS_NORMAL);
    job(4'hC, 1'b0, 1'b0, 8'hF0, 8'h10, PPFS_GLOSSY_FILM);
    job(4'hB, 1'b0, 1'b1, 8'h00, 8'h40, PPFS_HEAVY2);
    job(4'h3, 1'b1, 1'b0, 8'h00, 8'hF0, PPFS_TRANSPARENCY);
    for (int k = 0; k < 10; k++) begin
      g = 8'(k > 3 ? 160 + $urandom % 64 : $urandom % 160);
      t = 8'(16 + 48 * (k % 4) + $urandom % 32);
      if (k == 8) g = 8'(224 + $urandom % 32);
      if (k == 9) t = 8'(224 + $urandom % 32);
      job(4'h0, 1'b0, k[0], g, t, tbl[k]);
    end
    print_verdict();
  end
endmodule : ppfs_seq_tb
